//--- ctwo_core.sv
// Decoder and executor for test, index-to-accumulator transfer and wait
module ctwo_core
  import ctwo_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] mem_rdata,
  input wire logic wake,
  output ctwo_mem_req_t mem_req,
  output ctwo_regs_t regs,
  output logic cpu_clk_stop,
  output logic instr_done,
  output logic illegal_op
);
  ctwo_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] idx_q, idx_d;
  logic [4:0] ccr_q, ccr_d;
  logic [7:0] op_q, op_d;
  logic [7:0] offh_q, offh_d;
  logic [7:0] offl_q, offl_d;
  logic [3:0] cnt_q, cnt_d;
  ctwo_ixmode_t ixm_q, ixm_d;
  logic [15:0] ea;
  ctwo_mem_req_t req_q, req_d;
  logic stop_q, stop_d;
  logic done_q, done_d;
  logic ill_q, ill_d;

  ctwo_ea u_ea (
    .mode(ixm_q),
    .idx(idx_q),
    .off_hi(offh_q),
    .off_lo(offl_q),
    .ea(ea)
  );

  // Flags from a subtract of zero: only N and Z move
  function automatic logic [4:0] tst_flags(input logic [4:0] c, input logic [7:0] v);
    logic [4:0] r;
    r = c;
    r[CCR_N] = v[7];
    r[CCR_Z] = (v == 8'h00);
    return r;
  endfunction

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    acc_d = acc_q;
    idx_d = idx_q;
    ccr_d = ccr_q;
    op_d = op_q;
    offh_d = offh_q;
    offl_d = offl_q;
    ixm_d = ixm_q;
    stop_d = stop_q;
    done_d = 1'b0;
    ill_d = 1'b0;
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    req_d.rd = 1'b0;
    req_d.addr = req_q.addr;
    case (state_q)
      CTWO_FETCH: begin
        // Opcode is on mem_rdata for the address presented this cycle
        op_d = mem_rdata;
        pc_d = pc_q + 16'h0001;
        case (mem_rdata)
          OP_TST_DIR, OP_TST_IX1: begin
            ixm_d = CTWO_IX_SHORT;
            // Count is the cycle total less one: the registered done pulse falls on the cycle after the last, with the next fetch
            cnt_d = (mem_rdata == OP_TST_DIR) ? CYC_TST_DIR - 4'h1 : CYC_TST_IX1 - 4'h1;
            req_d = '{addr: pc_q + 16'h0001, rd: 1'b1};
            state_d = CTWO_OPND1;
          end
          OP_TST_IX0: begin
            ixm_d = CTWO_IX_NONE;
            cnt_d = CYC_TST_IX0 - 4'h1;
            req_d = '{addr: {8'h00, idx_q}, rd: 1'b1};
            state_d = CTWO_READ;
          end
          OP_TST_ACC: begin
            ccr_d = tst_flags(ccr_q, acc_q);
            cnt_d = CYC_TST_INH - 4'h1;
            state_d = CTWO_PAD;
          end
          OP_TST_IDX: begin
            ccr_d = tst_flags(ccr_q, idx_q);
            cnt_d = CYC_TST_INH - 4'h1;
            state_d = CTWO_PAD;
          end
          OP_TXA: begin
            acc_d = idx_q;
            cnt_d = CYC_TXA - 4'h1;
            state_d = CTWO_PAD;
          end
          OP_WAIT: begin
            ccr_d[CCR_I] = 1'b0;
            cnt_d = CYC_WAIT - 4'h1;
            state_d = CTWO_PAD;
          end
          default: begin
            // Opcodes of other table portions are flagged and skipped
            ill_d = 1'b1;
            cnt_d = CYC_ILLEGAL - 4'h1;
            state_d = CTWO_PAD;
          end
        endcase
      end
      CTWO_OPND1: begin
        // Offset or direct address byte; the long form takes the high byte first
        if (ixm_q == CTWO_IX_LONG) begin
          offh_d = mem_rdata;
          pc_d = pc_q + 16'h0001;
          req_d = '{addr: pc_q + 16'h0001, rd: 1'b1};
          state_d = CTWO_OPND2;
        end else begin
          offl_d = mem_rdata;
          pc_d = pc_q + 16'h0001;
          if (op_q == OP_TST_DIR) begin
            req_d = '{addr: {8'h00, mem_rdata}, rd: 1'b1};
          end else begin
            req_d = '{addr: {8'h00, idx_q} + {8'h00, mem_rdata}, rd: 1'b1};
          end
          state_d = CTWO_READ;
        end
      end
      CTWO_OPND2: begin
        offl_d = mem_rdata;
        pc_d = pc_q + 16'h0001;
        req_d = '{addr: {offh_q, mem_rdata} + {8'h00, idx_q}, rd: 1'b1};
        state_d = CTWO_READ;
      end
      CTWO_READ: begin
        // Read only: no write strobe exists, memory is never modified
        ccr_d = tst_flags(ccr_q, mem_rdata);
        state_d = CTWO_PAD;
      end
      CTWO_PAD: begin
        if (cnt_q <= 4'h1) begin
          done_d = 1'b1;
          if (op_q == OP_WAIT) begin
            stop_d = 1'b1;
            state_d = CTWO_WAITING;
          end else begin
            req_d = '{addr: pc_q, rd: 1'b1};
            state_d = CTWO_FETCH;
          end
        end
      end
      CTWO_WAITING: begin
        // Wake sources live outside; a wake restarts fetching at the next opcode
        if (wake) begin
          stop_d = 1'b0;
          req_d = '{addr: pc_q, rd: 1'b1};
          state_d = CTWO_FETCH;
        end
      end
      default: state_d = CTWO_FETCH;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= CTWO_PAD;
      pc_q <= PC_RESET;
      acc_q <= ACC_RESET;
      idx_q <= IDX_RESET;
      ccr_q <= CCR_RESET;
      op_q <= 8'h00;
      offh_q <= 8'h00;
      offl_q <= 8'h00;
      ixm_q <= CTWO_IX_NONE;
      cnt_q <= 4'h0;
      req_q <= '0;
      stop_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      ccr_q <= ccr_d;
      op_q <= op_d;
      offh_q <= offh_d;
      offl_q <= offl_d;
      ixm_q <= ixm_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      stop_q <= stop_d;
      done_q <= done_d;
      ill_q <= ill_d;
    end
  end

  assign mem_req = req_q;
  assign regs = '{acc: acc_q, idx: idx_q, condition_code_reg: ccr_q};
  assign cpu_clk_stop = stop_q;
  assign instr_done = done_q;
  assign illegal_op = ill_q;
endmodule

//--- ctwo_pkg.sv
// Constants and types for the test, transfer and wait instruction decoder
package ctwo_pkg;
  localparam logic [7:0] OP_TST_DIR = 8'h3d;
  localparam logic [7:0] OP_TST_ACC = 8'h4d;
  localparam logic [7:0] OP_TST_IDX = 8'h5d;
  localparam logic [7:0] OP_TST_IX1 = 8'h6d;
  localparam logic [7:0] OP_TST_IX0 = 8'h7d;
  localparam logic [7:0] OP_TXA = 8'h9f;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [3:0] CYC_TST_DIR = 4'h4;
  localparam logic [3:0] CYC_TST_INH = 4'h3;
  localparam logic [3:0] CYC_TST_IX1 = 4'h5;
  localparam logic [3:0] CYC_TST_IX0 = 4'h4;
  localparam logic [3:0] CYC_TXA = 4'h2;
  localparam logic [3:0] CYC_WAIT = 4'h2;
  localparam logic [3:0] CYC_ILLEGAL = 4'h2;
  localparam int CCR_C = 0;
  localparam int CCR_Z = 1;
  localparam int CCR_N = 2;
  localparam int CCR_I = 3;
  localparam int CCR_H = 4;
  localparam logic [4:0] CCR_RESET = 5'h08;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CTWO_IX_NONE = 2'b00,
    CTWO_IX_SHORT = 2'b01,
    CTWO_IX_LONG = 2'b10
  } ctwo_ixmode_t;

  typedef enum logic [2:0] {
    CTWO_FETCH = 3'b000,
    CTWO_OPND1 = 3'b001,
    CTWO_OPND2 = 3'b010,
    CTWO_READ = 3'b011,
    CTWO_PAD = 3'b100,
    CTWO_WAITING = 3'b101
  } ctwo_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
  } ctwo_mem_req_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx;
    logic [4:0] condition_code_reg;
  } ctwo_regs_t;
endpackage

//--- ctwo_ea.sv
// Indexed effective address former for the three indexed modes
module ctwo_ea
  import ctwo_pkg::*;
(
  input wire ctwo_ixmode_t mode,
  input wire logic [7:0] idx,
  input wire logic [7:0] off_hi,
  input wire logic [7:0] off_lo,
  output logic [15:0] ea
);
  always_comb begin
    case (mode)
      CTWO_IX_NONE: ea = {8'h00, idx};
      CTWO_IX_SHORT: ea = {8'h00, idx} + {8'h00, off_lo};
      CTWO_IX_LONG: ea = {off_hi, off_lo} + {8'h00, idx};
      default: ea = {8'h00, idx};
    endcase
  end
endmodule

//--- ctwo_core_monitor.sv
// Port checker for the decoder core
module ctwo_core_monitor
  import ctwo_pkg::*;
(
  input logic mclk,
  input logic sys_rst,
  input logic [7:0] mem_rdata,
  input logic wake,
  input ctwo_mem_req_t mem_req,
  input ctwo_regs_t regs,
  input logic cpu_clk_stop,
  input logic instr_done,
  input logic illegal_op
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Opcode fetch, except the one after a wake, coincides with the done pulse of the previous instruction
  sequence s_op(logic [7:0] op);
    instr_done && mem_req.rd && mem_rdata == op;
  endsequence
  a_xfer_copy: assert property (
    s_op(OP_TXA) |=> regs.acc == $past(regs.idx) && regs.condition_code_reg == $past(regs.condition_code_reg))
    else $error("bad transfer");
  a_xfer_two: assert property (
    s_op(OP_TXA) |-> ##1 !instr_done ##1 instr_done) else $error("transfer length");
  a_wait_unmask: assert property (
    s_op(OP_WAIT) |=> !regs.condition_code_reg[CCR_I]) else $error("mask not cleared");
  a_wait_stop: assert property (
    s_op(OP_WAIT) |-> ##2 instr_done && cpu_clk_stop) else $error("clock not stopped");
  a_stop_quiet: assert property (
    cpu_clk_stop && !wake |=> !mem_req.rd) else $error("read while stopped");
  a_test_flags: assert property (
    s_op(OP_TST_ACC) |-> ##3 instr_done && regs.condition_code_reg[CCR_Z] == (regs.acc == 8'h00)
    && regs.condition_code_reg[CCR_N] == regs.acc[7]) else $error("bad test flags");
  a_carry_kept: assert property (
    $stable({regs.condition_code_reg[CCR_C], regs.condition_code_reg[CCR_H]})) else $error("carry or half moved");
  a_ix0_addr: assert property (
    s_op(OP_TST_IX0) |=> mem_req.rd && mem_req.addr == {8'h00, regs.idx})
    else $error("bad indexed address");
endmodule

bind ctwo_core ctwo_core_monitor i_ctwo_core_monitor(.mclk(mclk), .sys_rst(sys_rst),
  .mem_rdata(mem_rdata), .wake(wake), .mem_req(mem_req), .regs(regs),
  .cpu_clk_stop(cpu_clk_stop), .instr_done(instr_done), .illegal_op(illegal_op));

//--- ctwo_mem_model.sv
// Program memory answering one byte per read
module ctwo_mem_model
  import ctwo_pkg::*;
(
  input logic mclk,
  input ctwo_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] last_q = 8'h00;
  // Page zero only; no write path, so memory can never change
  always_ff @(posedge mclk) begin
    if (mem_req.rd) last_q <= mem[mem_req.addr[7:0]];
  end
  // Outside a read the bus shows the inverse, not a stale byte
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr[7:0]] : ~last_q;
endmodule

//--- tb_top.sv
// Self-checking bench for the decoder core
module tb_top;
  import ctwo_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic wake = 1'b0;
  logic [7:0] mem_rdata;
  ctwo_mem_req_t mem_req;
  ctwo_regs_t regs;
  logic cpu_clk_stop;
  logic instr_done;
  logic illegal_op;
  logic bad_seen = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  int k;
  logic [15:0] rdq[$];
  logic [7:0] prog [11] = '{8'h3d, 8'h40, 8'h4d, 8'h5d, 8'h6d, 8'h41, 8'h7d, 8'h9f,
    8'h01, 8'h8f, 8'h4d};
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    #1;
    if (mem_req.rd === 1'b1) rdq.push_back(mem_req.addr);
    if (illegal_op === 1'b1) bad_seen = 1'b1;
  end
  ctwo_core i_ctwo_core(.mclk(mclk), .sys_rst(sys_rst), .mem_rdata(mem_rdata),
    .wake(wake), .mem_req(mem_req), .regs(regs), .cpu_clk_stop(cpu_clk_stop),
    .instr_done(instr_done), .illegal_op(illegal_op));
  ctwo_mem_model i_ctwo_mem_model(.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Waits for a done pulse, then checks length and flags
  task automatic step(input logic [3:0] cyc, input logic [4:0] condition_code_reg);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (instr_done !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      final_report();
    end
    if (cyc != 4'h0) check(16'(n), {12'h000, cyc});
    check({11'h000, regs.condition_code_reg}, {11'h000, condition_code_reg});
  endtask
  task automatic t_direct();
    step(CYC_TST_DIR, 5'h0c);
    check(rdq[rdq.size()-2], 16'h0040);
    $display("direct done");
  endtask
  task automatic t_inherent();
    step(CYC_TST_INH, 5'h0a);
    step(CYC_TST_INH, 5'h0a);
    $display("inherent done");
  endtask
  task automatic t_short();
    step(CYC_TST_IX1, 5'h0a);
    check(rdq[rdq.size()-2], 16'h0041);
    $display("short done");
  endtask
  task automatic t_none();
    step(CYC_TST_IX0, 5'h08);
    check(rdq[rdq.size()-2], 16'h0000);
    check(rdq[rdq.size()-3], 16'h0006);
    $display("none done");
  endtask
  task automatic t_xfer();
    step(CYC_TXA, 5'h08);
    check({8'h00, regs.acc}, {8'h00, IDX_RESET});
    step(CYC_ILLEGAL, 5'h08);
    check({15'h0000, bad_seen}, 16'h0001);
    $display("xfer done");
  endtask
  task automatic t_wait();
    step(CYC_WAIT, 5'h00);
    k = rdq.size();
    repeat (6) @(negedge mclk);
    check(16'(rdq.size() - k), 16'h0000);
    check({15'h0000, cpu_clk_stop}, 16'h0001);
    wake = 1'b1;
    step(4'h0, 5'h02);
    wake = 1'b0;
    check({15'h0000, cpu_clk_stop}, 16'h0000);
    $display("wait done");
  endtask
  initial begin
    foreach (prog[i]) i_ctwo_mem_model.mem[i] = prog[i];
    i_ctwo_mem_model.mem[64] = 8'h80;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    step(4'h0, CCR_RESET);
    t_direct();
    t_inherent();
    t_short();
    t_none();
    t_xfer();
    t_wait();
    final_report();
  end
endmodule
